// ---- hdl/qmiu_top.sv ----
// Interrupt enable and status unit for the queue manager and MAC events.
`timescale 1ns/1ns
module qmiu_top
  import qmiu_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic [qmiu_pkg::QMIU_AW-1:0]  addr,
  input  wire logic [qmiu_pkg::QMIU_DW-1:0]  wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [qmiu_pkg::QMIU_DW-1:0]  rdata,
  input  wire logic                          link_up,
  input  wire logic                          tx_done,
  input  wire logic                          rx_done,
  input  wire logic                          tx_underrun,
  input  wire logic                          rx_overrun,
  input  wire logic                          early_rx,
  input  wire logic                          tx_stopped,
  input  wire logic                          rx_stopped,
  input  wire logic                          rx_error_frame,
  output logic                               irq
);
  import qmiu_pkg::*;

  logic [15:0] enable_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] rdata_nxt;
  logic [15:0] event_w;
  logic [15:0] clear_w;
  logic [8:0]  src_w;
  logic [8:0]  pulse_w;

  // Event inputs in status bit order, 15 down to 7
  assign src_w = {link_up, tx_done, rx_done, tx_underrun, rx_overrun,
                  early_rx, tx_stopped, rx_stopped, rx_error_frame};

  // One detector per source; link uses both edges
  genvar gi;
  generate
    for (gi = 0; gi < QMIU_NSRC; gi++)
    begin : g_src
      qmiu_edge u_edge
      (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .ce       (ce),
        .din      (src_w[gi]),
        .any_edge (gi == QMIU_NSRC - 1),
        .pulse    (pulse_w[gi])
      );
    end
  endgenerate

  assign event_w = qmiu_place(pulse_w); // see RULE5 see RULE6 see RULE7 see RULE8 see RULE9
  // Remaining sources share the same placement
  // see RULE10 see RULE11 see RULE12 see RULE13

  // Write-one-to-clear only; a read never touches status
  assign clear_w = (ce && wr && addr == QMIU_OFS_STATUS) ? (wdata & QMIU_FIELD_MASK)
                                                         : QMIU_ZERO; // see RULE3

  // Set beats clear so a coincident event survives
  assign status_nxt = (status_r & ~clear_w) | event_w; // see RULE4 see RULE15

  // Enable register, reserved bits held at zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      enable_r <= QMIU_ENABLE_RST; // see RULE1
    else if (ce && wr && addr == QMIU_OFS_ENABLE)
      enable_r <= wdata & QMIU_FIELD_MASK; // see RULE1
  end

  // Status register; stopped bits start set
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      status_r <= QMIU_STATUS_RST; // see RULE11 see RULE12
    else if (ce)
      status_r <= status_nxt;
  end

  // Read mux; unmapped addresses answer zero
  always_comb
  begin
    case (addr)
      QMIU_OFS_ENABLE: rdata_nxt = enable_r;
      QMIU_OFS_STATUS: rdata_nxt = status_r;
      QMIU_OFS_LINK:   rdata_nxt = {15'h0000, link_up};
      default:         rdata_nxt = QMIU_ZERO;
    endcase
  end

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rdata <= QMIU_ZERO;
    else if (ce && rd)
      rdata <= rdata_nxt;
  end

  // Level interrupt, falls as soon as no enabled flag stands
  assign irq = |(status_r & enable_r); // see RULE2 see RULE14

  // Checks
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq == |(status_r & enable_r & QMIU_FIELD_MASK)) // see RULE2
    else $error("irq does not follow enabled status");
  a_irq_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (status_r & enable_r) == QMIU_ZERO |-> !irq) // see RULE14
    else $error("irq high with nothing enabled");
  a_read_keeps: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && rd && !wr && event_w == QMIU_ZERO |=> status_r == $past(status_r)) // see RULE3
    else $error("read changed status");
  a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && wr && addr == QMIU_OFS_STATUS && wdata[QMIU_BIT_TXUND]
    && !pulse_w[QMIU_BIT_TXUND - QMIU_LSB]
    |=> !status_r[QMIU_BIT_TXUND]) // see RULE4
    else $error("write one did not clear");
  a_w0_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && wr && addr == QMIU_OFS_STATUS && !wdata[QMIU_BIT_RXOVR] && status_r[QMIU_BIT_RXOVR]
    |=> status_r[QMIU_BIT_RXOVR]) // see RULE4
    else $error("write zero cleared a bit");
  a_link_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && $past(ce) && link_up != $past(link_up) |=> status_r[QMIU_BIT_LINK]) // see RULE5
    else $error("link change not flagged");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && rx_done && !$past(rx_done) && $past(ce) && wr && addr == QMIU_OFS_STATUS
    |=> status_r[QMIU_BIT_RXDONE]) // see RULE15
    else $error("event lost to clear");
  a_enable_rsv: assert property (@(posedge ref_clk) disable iff (!rstn)
    enable_r[6:0] == 7'h00 && status_r[6:0] == 7'h00) // see RULE1
    else $error("reserved bits set");
  a_txund_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE8
    pulse_w[QMIU_BIT_TXUND - QMIU_LSB] |=> status_r[QMIU_BIT_TXUND])
    else $error("underrun not flagged");

  // Per-source capture, judged from the raw input levels rather than the detector
  a_txdone_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE6
    ce && $past(ce) && tx_done && !$past(tx_done) |=> status_r[QMIU_BIT_TXDONE])
    else $error("transmit done not flagged");
  a_rxdone_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE7
    ce && $past(ce) && rx_done && !$past(rx_done) |=> status_r[QMIU_BIT_RXDONE])
    else $error("receive done not flagged");
  a_rxovr_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE9
    ce && $past(ce) && rx_overrun && !$past(rx_overrun) |=> status_r[QMIU_BIT_RXOVR])
    else $error("receive overrun not flagged");
  a_early_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE10
    ce && $past(ce) && early_rx && !$past(early_rx) |=> status_r[QMIU_BIT_EARLY])
    else $error("early receive not flagged");
  a_txstop_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE11
    ce && $past(ce) && tx_stopped && !$past(tx_stopped) |=> status_r[QMIU_BIT_TXSTOP])
    else $error("transmit stop not flagged");
  a_rxstop_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE12
    ce && $past(ce) && rx_stopped && !$past(rx_stopped) |=> status_r[QMIU_BIT_RXSTOP])
    else $error("receive stop not flagged");
  a_rxerr_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE13
    ce && $past(ce) && rx_error_frame && !$past(rx_error_frame) |=> status_r[QMIU_BIT_RXERR])
    else $error("receive error frame not flagged");

  c_irq_rise: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(irq));
  c_irq_fall: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(irq));
  c_collide:  cover property (@(posedge ref_clk) disable iff (!rstn)
    |(event_w & clear_w));

endmodule : qmiu_top

// ---- hdl/qmiu_pkg.sv ----
// Package of constants for the queue and MAC interrupt unit.
// Contract
// RULE1: The enable register has nine enable bits at 15 down to 7, each gating one source, all zero after reset.
// RULE2: The interrupt output is high whenever any status bit is set together with its enable bit.
// RULE3: Reading the status register never changes any status bit.
// RULE4: A status bit sets on its event and holds until the host writes one to it; writing zero leaves it.
// RULE5: Status bit 15 sets on every link state change, up to down or down to up, gated by enable 15.
// RULE6: Status bit 14 sets when a frame was sent and the transmit queue takes new frames, gated by enable 14.
// RULE7: Status bit 13 sets when the receive queue holds a frame ready for the host, gated by enable 13.
// RULE8: Status bit 12 sets on a transmit underrun, gated by enable 12.
// RULE9: Status bit 11 sets on a receive overrun, gated by enable 11.
// RULE10: Status bit 10 sets on an early receive, gated by enable 10.
// RULE11: Status bit 9 sets when the transmit process stops, is set after reset, gated by enable 9.
// RULE12: Status bit 8 sets when the receive process stops, is set after reset, gated by enable 8.
// RULE13: Status bit 7 sets on a receive error frame event, gated by enable 7.
// RULE14: The interrupt output falls once no set status bit has its enable set.
// RULE15: An event in the same cycle as a write of one to its bit keeps the bit set.
package qmiu_pkg;

  localparam int          QMIU_AW         = 4;
  localparam int          QMIU_DW         = 16;
  localparam int          QMIU_NSRC       = 9;
  // Register byte offsets
  localparam logic [3:0]  QMIU_OFS_ENABLE = 4'h0;
  localparam logic [3:0]  QMIU_OFS_STATUS = 4'h2;
  localparam logic [3:0]  QMIU_OFS_LINK   = 4'h4;
  // Field positions
  localparam int          QMIU_LSB        = 7;
  localparam int          QMIU_MSB        = 15;
  localparam int          QMIU_BIT_LINK   = 15;
  localparam int          QMIU_BIT_TXDONE = 14;
  localparam int          QMIU_BIT_RXDONE = 13;
  localparam int          QMIU_BIT_TXUND  = 12;
  localparam int          QMIU_BIT_RXOVR  = 11;
  localparam int          QMIU_BIT_EARLY  = 10;
  localparam int          QMIU_BIT_TXSTOP = 9;
  localparam int          QMIU_BIT_RXSTOP = 8;
  localparam int          QMIU_BIT_RXERR  = 7;
  // Reset values
  localparam logic [15:0] QMIU_ENABLE_RST = 16'h0000;
  localparam logic [15:0] QMIU_STATUS_RST = 16'h0300;
  localparam logic [15:0] QMIU_FIELD_MASK = 16'hff80;
  localparam logic [15:0] QMIU_ZERO       = 16'h0000;

  // Events land in bits 15..7 of a status word
  function automatic logic [15:0] qmiu_place(input logic [8:0] ev);
    qmiu_place = {ev, 7'h00};
  endfunction : qmiu_place

endpackage : qmiu_pkg

// ---- hdl/qmiu_edge.sv ----
// Rising edge and change detector for one event source.
`timescale 1ns/1ns
module qmiu_edge
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic din,
  input  wire logic any_edge,
  output logic      pulse
);
  logic din_r;

  // Previous sample; starts low so a level high at release counts once
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      din_r <= 1'b0;
    else if (ce)
      din_r <= din;
  end

  // Either direction for link change, else rising only
  assign pulse = ce && (any_edge ? (din ^ din_r) : (din & ~din_r));

endmodule : qmiu_edge

// ---- bench/qmiu_evt_model.sv ----
// Model of the queue and MAC event sources feeding the interrupt unit.
`timescale 1ns/1ns
module qmiu_evt_model
(
  input  wire logic       ref_clk,
  input  wire logic [8:0] fire,
  output logic      [8:0] ev
);
  initial ev = 9'h000;
  // Link level toggles per request; other sources give a one-cycle level
  // Plain always so the power-up value above can share the variable
  always @(posedge ref_clk)
  begin
    ev[8]   <= ev[8] ^ fire[8];
    ev[7:0] <= fire[7:0];
  end
endmodule : qmiu_evt_model

// ---- bench/qmiu_top_tb_top.sv ----
// Self-checking bench for the queue and MAC interrupt unit.
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module qmiu_top_tb_top;
  import qmiu_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [8:0]  fire    = 9'h000;
  logic [8:0]  ev;
  logic [15:0] rdata;
  logic        irq;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  qmiu_top qmiu_top_inst (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_up(ev[8]), .tx_done(ev[7]),
    .rx_done(ev[6]), .tx_underrun(ev[5]), .rx_overrun(ev[4]), .early_rx(ev[3]),
    .tx_stopped(ev[2]), .rx_stopped(ev[1]), .rx_error_frame(ev[0]), .irq(irq));
  qmiu_evt_model qmiu_evt_model_inst (.ref_clk(ref_clk), .fire(fire), .ev(ev));
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stand from the cycle after the strobe until the next read strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  // Request one source through the model, then let it settle
  task automatic fire_src(input int b);
    @(posedge ref_clk);
    fire <= 9'h001 << (b - QMIU_LSB);
    @(posedge ref_clk);
    fire <= 9'h000;
    repeat (3) @(posedge ref_clk);
  endtask : fire_src
  task automatic t_reset_and_map();
    rd_chk(QMIU_OFS_ENABLE, 16'h0000);
    rd_chk(QMIU_OFS_STATUS, 16'h0300);
    `CHK(irq, 1'b0)
    wr_reg(QMIU_OFS_STATUS, 16'h0000);
    rd_chk(QMIU_OFS_STATUS, 16'h0300);
    wr_reg(QMIU_OFS_STATUS, 16'h0300);
    rd_chk(QMIU_OFS_STATUS, 16'h0000);
    wr_reg(QMIU_OFS_ENABLE, 16'hffff);
    rd_chk(QMIU_OFS_ENABLE, 16'hff80);
    wr_reg(QMIU_OFS_ENABLE, 16'h0000);
    rd_chk(4'h6, 16'h0000);
  endtask : t_reset_and_map
  // Every source sets its own bit, and only its own enable raises the line
  task automatic t_each_source();
    for (int b = QMIU_MSB; b >= QMIU_LSB; b--)
    begin
      fire_src(b);
      rd_chk(QMIU_OFS_STATUS, 16'h0001 << b);
      rd_chk(QMIU_OFS_STATUS, 16'h0001 << b);
      `CHK(irq, 1'b0)
      wr_reg(QMIU_OFS_ENABLE, 16'h0001 << b);
      `CHK(irq, 1'b1)
      wr_reg(QMIU_OFS_ENABLE, ~(16'h0001 << b) & QMIU_FIELD_MASK);
      `CHK(irq, 1'b0)
      wr_reg(QMIU_OFS_ENABLE, 16'h0001 << b);
      wr_reg(QMIU_OFS_STATUS, 16'h0001 << b);
      `CHK(irq, 1'b0)
      wr_reg(QMIU_OFS_ENABLE, 16'h0000);
    end
    fire_src(QMIU_BIT_LINK);
    rd_chk(QMIU_OFS_STATUS, 16'h8000);
    wr_reg(QMIU_OFS_STATUS, 16'h8000);
  endtask : t_each_source
  // Clear write lands on the edge that captures a new event
  task automatic t_set_wins();
    @(posedge ref_clk);
    fire <= 9'h020;
    @(posedge ref_clk);
    fire  <= 9'h000;
    addr  <= QMIU_OFS_STATUS;
    wdata <= 16'h1000;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd_chk(QMIU_OFS_STATUS, 16'h1000);
  endtask : t_set_wins
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the roughly 220 cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset_and_map();
    t_each_source();
    t_set_wins();
    print_verdict();
  end
endmodule : qmiu_top_tb_top
